/* rcsm_pkg.sv */
package rcsm_pkg;
	localparam int SW_W     = 8;
	localparam int NUM_CIG  = 3;
	localparam int NUM_ORG  = 11;
	localparam int NUM_GRP  = NUM_CIG + NUM_ORG;
	localparam int NUM_STG  = 6;
	localparam int NUM_OUT  = 4;
	localparam int NUM_CUR  = 4;
	localparam int ADDR_W   = 8;
	localparam int CUR_W_DEF = 12;

	// byte addresses of the register map
	localparam logic [ADDR_W-1:0] ADDR_BANK_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_LATCH_EN = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_DISP_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_SWGRP    = 8'h40;
	localparam logic [ADDR_W-1:0] ADDR_CKSUM    = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_RECORD   = 8'hC0;

	// switch positions inside a control-input group (switch n sits at bit n-1)
	localparam int SW_BLOCK_LO = 0;
	localparam int NUM_BLK_SW  = 4;
	localparam int SW_BANK     = 4;
	localparam int SW_SIX      = 5;
	localparam int SW_CLR_LATCH = 6;
	localparam int SW_CLR_REG  = 7;
	localparam int STG_UNBAL   = 5;

	// routing bits inside an output-routing group
	localparam int OUT_SS_LSB  = 0;
	localparam int OUT_TS_LSB  = 4;
	localparam int NUM_SIG     = 11;

	// status word layout
	localparam int ST_BANK     = 0;
	localparam int ST_BLOCK    = 1;
	localparam int ST_SS       = 7;
	localparam int ST_TS       = 11;
	localparam int ST_IND      = 15;

	localparam logic [SW_W-1:0] RST_SW       = 8'h00;
	localparam logic [NUM_OUT-1:0] RST_LATCH = 4'h0;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam logic [11:0] DISP_MAX  = 12'h3E7;
	localparam logic [6:0]  PCT_SCALE = 7'h64;

	localparam int CLK_NS       = 8;
	localparam int DISP_UPD_NS  = 10000;
	localparam int DISP_UPD_CYC = DISP_UPD_NS / CLK_NS;

	typedef enum logic [2:0] {
		DISP_L1    = 3'h0,
		DISP_L2    = 3'h1,
		DISP_L3    = 3'h2,
		DISP_RES   = 3'h3,
		DISP_UNBAL = 3'h4
	} rcsm_disp_type;
endpackage

/* rcsm_route_if.sv */
`timescale 1ns/100ps
interface rcsm_route_if;
	logic [rcsm_pkg::NUM_SIG-1:0]                  sig;
	logic [rcsm_pkg::NUM_SIG-1:0][rcsm_pkg::SW_W-1:0] route;
	logic [rcsm_pkg::SW_W-1:0]                     hit;
	modport src (output sig, output route, input hit);
	modport mtx (input sig, input route, output hit);
endinterface

/* rcsm_route.sv */
`timescale 1ns/100ps
module rcsm_route (
	rcsm_route_if.mtx rif	// stage signals in, output hits back
);
	genvar k, j;
	for (k = 0; k < rcsm_pkg::SW_W; k++) begin : g_out
		logic [rcsm_pkg::NUM_SIG-1:0] col;
		for (j = 0; j < rcsm_pkg::NUM_SIG; j++) begin : g_sig
			assign col[j] = rif.route[j][k];
		end
		assign rif.hit[k] = |(rif.sig & col);
	end
endmodule

/* rcsm_top.sv */
// Contract
// - group switch 1-4 blocks stage while input high
// - bank switch 0: inputs cannot select bank
// - bank switch 1: input level alone picks bank
// - bus command also selects main or second bank
// - group 1 switch 6 blocks unbalance stage
// - groups 2,3 switch 6 clear indicators only
// - switch 7 clears indicators and latched outputs
// - switch 8 also clears recorded registers
// - eleven routing groups map signals to outputs
// - show selected value, light its indicator
// - unbalance is max-min phase percentage
// - checksum sums weights of set switches
// - three groups define two blocking, one clear input
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module rcsm_top #(
	parameter int CUR_W = rcsm_pkg::CUR_W_DEF
) (
	input  wire logic                          CLOCK,            // 125 MHz clock
	input  wire logic                          RST_B,            // async reset, active low
	input  wire logic                          EXT_BLOCK_IN_A,   // first external control input
	input  wire logic                          EXT_BLOCK_IN_B,   // second external control input
	input  wire logic                          REMOTE_CLEAR_IN,  // third external control input
	input  wire logic [rcsm_pkg::NUM_STG-1:0]  STAGE_START,      // stage start signals
	input  wire logic [rcsm_pkg::NUM_STG-1:0]  STAGE_OPER,       // stage operate signals
	input  wire logic [CUR_W-1:0]              CUR_L1,           // phase L1 current
	input  wire logic [CUR_W-1:0]              CUR_L2,           // phase L2 current
	input  wire logic [CUR_W-1:0]              CUR_L3,           // phase L3 current
	input  wire logic [CUR_W-1:0]              RESIDUAL_CURRENT, // residual current
	input  wire logic [rcsm_pkg::ADDR_W-1:0]   AWADDR,           // write address
	input  wire logic [2:0]                    AWPROT,           // write protection, unused
	input  wire logic                          AWVALID,          // write address valid
	output logic                               AWREADY,          // write address ready
	input  wire logic [31:0]                   WDATA,            // write data
	input  wire logic [3:0]                    WSTRB,            // write strobes
	input  wire logic                          WVALID,           // write data valid
	output logic                               WREADY,           // write data ready
	output logic [1:0]                         BRESP,            // write response
	output logic                               BVALID,           // write response valid
	input  wire logic                          BREADY,           // write response ready
	input  wire logic [rcsm_pkg::ADDR_W-1:0]   ARADDR,           // read address
	input  wire logic [2:0]                    ARPROT,           // read protection, unused
	input  wire logic                          ARVALID,          // read address valid
	output logic                               ARREADY,          // read address ready
	output logic [31:0]                        RDATA,            // read data
	output logic [1:0]                         RRESP,            // read response
	output logic                               RVALID,           // read data valid
	input  wire logic                          RREADY,           // read data ready
	output logic [rcsm_pkg::NUM_STG-1:0]       STAGE_BLOCK,      // stage blocked
	output logic                               BANK_SEL,         // 1 = second settings
	output logic [rcsm_pkg::NUM_OUT-1:0]       START_OUTPUTS,    // start outputs
	output logic [rcsm_pkg::NUM_OUT-1:0]       TRIP_OUTPUTS,     // trip outputs
	output logic [rcsm_pkg::NUM_OUT-1:0]       TRIP_IND,         // front-panel operation indicators
	output logic [11:0]                        DISP_VALUE,       // three-digit display value
	output logic [3:0]                         DISP_LED          // yellow quantity indicators
);
	localparam int NUMW = CUR_W + 7;

	if (CUR_W < 10 || CUR_W > 16) begin : g_bad_width
		$error("rcsm_top: CUR_W must lie in 10..16");
	end

	rcsm_route_if rif ();

	logic [rcsm_pkg::SW_W-1:0]          swgrp [rcsm_pkg::NUM_GRP];
	logic                               bank_cmd;
	logic [rcsm_pkg::NUM_OUT-1:0]       latch_en;
	rcsm_pkg::rcsm_disp_type            disp_sel;
	logic [rcsm_pkg::NUM_OUT-1:0]       trip_hold;
	logic [CUR_W-1:0]                   rec [rcsm_pkg::NUM_CUR];
	logic [CUR_W-1:0]                   cur [rcsm_pkg::NUM_CUR];
	logic                               aw_got;
	logic                               w_got;
	logic [rcsm_pkg::ADDR_W-1:0]        aw_addr;
	logic [rcsm_pkg::SW_W-1:0]          w_byte;
	logic                               w_lane;
	logic [2:0]                         ctl_in;
	logic [rcsm_pkg::NUM_STG-1:0]       next_block;
	logic                               next_bank;
	logic                               clr_ind;
	logic                               clr_latch;
	logic                               clr_reg;
	logic [rcsm_pkg::NUM_SIG-1:0]       sig;
	logic                               start_any;
	logic [rcsm_pkg::NUM_OUT-1:0]       hit_ts;
	logic [rcsm_pkg::NUM_OUT-1:0]       hold_keep;
	logic [31:0]                        rd_data;
	logic                               rd_ok;
	logic                               wr_ok;
	logic [15:0]                        upd_cnt;
	logic [4:0]                         div_cnt;
	logic                               div_busy;
	logic [NUMW-1:0]                    quo;
	logic [CUR_W:0]                     rem;
	logic [CUR_W-1:0]                   den;
	logic [CUR_W:0]                     rem_sh;
	logic [7:0]                         unbal;
	logic [CUR_W-1:0]                   ph_max;
	logic [CUR_W-1:0]                   ph_min;
	logic [CUR_W-1:0]                   disp_src;

	assign cur[0] = CUR_L1;
	assign cur[1] = CUR_L2;
	assign cur[2] = CUR_L3;
	assign cur[3] = RESIDUAL_CURRENT;
	assign ctl_in = {REMOTE_CLEAR_IN, EXT_BLOCK_IN_B, EXT_BLOCK_IN_A};

	function automatic logic [rcsm_pkg::SW_W-1:0] cksum(input logic [rcsm_pkg::SW_W-1:0] sw);
		logic [rcsm_pkg::SW_W-1:0] sum;
		sum = '0;
		for (int n = 0; n < rcsm_pkg::SW_W; n++) begin
			if (sw[n]) begin
				sum = sum + rcsm_pkg::SW_W'(1 << n);
			end
		end
		return sum;
	endfunction

	// decode of the three control inputs, each through its own group
	always_comb begin
		logic bank_ext_en;
		logic bank_ext_lvl;
		bank_ext_en  = 1'b0;
		bank_ext_lvl = 1'b0;
		next_block   = '0;
		clr_ind      = 1'b0;
		clr_latch    = 1'b0;
		clr_reg      = 1'b0;
		for (int g = 0; g < rcsm_pkg::NUM_CIG; g++) begin
			for (int b = 0; b < rcsm_pkg::NUM_BLK_SW; b++) begin
				if (swgrp[g][rcsm_pkg::SW_BLOCK_LO + b] && ctl_in[g]) begin
					next_block[b] = 1'b1;
				end
			end
			if (g == 0 && swgrp[g][rcsm_pkg::SW_SIX] && ctl_in[g]) begin
				next_block[rcsm_pkg::STG_UNBAL] = 1'b1;
			end
			if (g != 0 && swgrp[g][rcsm_pkg::SW_SIX] && ctl_in[g]) begin
				clr_ind = 1'b1;
			end
			if (swgrp[g][rcsm_pkg::SW_CLR_LATCH] && ctl_in[g]) begin
				clr_ind   = 1'b1;
				clr_latch = 1'b1;
			end
			if (swgrp[g][rcsm_pkg::SW_CLR_REG] && ctl_in[g]) begin
				clr_ind   = 1'b1;
				clr_latch = 1'b1;
				clr_reg   = 1'b1;
			end
			if (swgrp[g][rcsm_pkg::SW_BANK]) begin
				bank_ext_en  = 1'b1;
				bank_ext_lvl = bank_ext_lvl | ctl_in[g];
			end
		end
		// an enabled input overrides the bus command outright
		next_bank = bank_ext_en ? bank_ext_lvl : bank_cmd;
	end

	// start and operate of stages 0..4 pair up; only operate of the unbalance stage is routed
	always_comb begin
		for (int s = 0; s < rcsm_pkg::STG_UNBAL; s++) begin
			sig[2*s]   = STAGE_START[s] & ~next_block[s];
			sig[2*s+1] = STAGE_OPER[s] & ~next_block[s];
		end
		sig[rcsm_pkg::NUM_SIG-1] = STAGE_OPER[rcsm_pkg::STG_UNBAL] & ~next_block[rcsm_pkg::STG_UNBAL];
		for (int j = 0; j < rcsm_pkg::NUM_SIG; j++) begin
			rif.route[j] = swgrp[rcsm_pkg::NUM_CIG + j];
		end
	end
	assign rif.sig   = sig;
	assign start_any = |sig;
	assign hit_ts    = rif.hit[rcsm_pkg::OUT_TS_LSB +: rcsm_pkg::NUM_OUT];
	assign hold_keep = clr_latch ? '0 : trip_hold;

	rcsm_route u_route (
		.rif (rif.mtx)
	);

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			STAGE_BLOCK   <= '0;
			BANK_SEL      <= 1'b0;
			START_OUTPUTS <= '0;
			TRIP_OUTPUTS  <= '0;
			trip_hold     <= '0;
		end else begin
			STAGE_BLOCK   <= next_block;
			BANK_SEL      <= next_bank;
			START_OUTPUTS <= rif.hit[rcsm_pkg::OUT_SS_LSB +: rcsm_pkg::NUM_OUT];
			// a still-present trip re-latches in the release cycle
			trip_hold     <= hold_keep | (hit_ts & latch_en);
			TRIP_OUTPUTS  <= hit_ts | hold_keep;
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			TRIP_IND <= '0;
		end else begin
			TRIP_IND <= (clr_ind ? '0 : TRIP_IND) | hit_ts;
		end
	end

	// peak values held while any unblocked operate signal, or start signal of stages 0..4, is present
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			for (int k = 0; k < rcsm_pkg::NUM_CUR; k++) begin
				rec[k] <= '0;
			end
		end else begin
			for (int k = 0; k < rcsm_pkg::NUM_CUR; k++) begin
				if (start_any && cur[k] > (clr_reg ? '0 : rec[k])) begin
					rec[k] <= cur[k];
				end else if (clr_reg) begin
					rec[k] <= '0;
				end
			end
		end
	end

	always_comb begin
		ph_max = CUR_L1;
		ph_min = CUR_L1;
		for (int k = 1; k < rcsm_pkg::NUM_CUR - 1; k++) begin
			if (cur[k] > ph_max) begin
				ph_max = cur[k];
			end
			if (cur[k] < ph_min) begin
				ph_min = cur[k];
			end
		end
		rem_sh = {rem[CUR_W-1:0], quo[NUMW-1]};
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			upd_cnt <= '0;
		end else if (upd_cnt == 16'(rcsm_pkg::DISP_UPD_CYC - 1)) begin
			upd_cnt <= '0;
		end else begin
			upd_cnt <= upd_cnt + 16'h0001;
		end
	end

	// restoring divider; a serial divide of the scaled difference keeps the area small at the cost of latency
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			div_cnt  <= '0;
			div_busy <= 1'b0;
			quo      <= '0;
			rem      <= '0;
			den      <= '0;
			unbal    <= '0;
		end else if (!div_busy && upd_cnt == '0) begin
			quo      <= NUMW'((ph_max - ph_min) * rcsm_pkg::PCT_SCALE);
			den      <= ph_max;
			rem      <= '0;
			div_cnt  <= 5'(NUMW);
			div_busy <= 1'b1;
		end else if (div_busy && div_cnt != '0) begin
			div_cnt <= div_cnt - 5'h01;
			if (rem_sh >= {1'b0, den}) begin
				rem <= rem_sh - {1'b0, den};
				quo <= {quo[NUMW-2:0], 1'b1};
			end else begin
				rem <= rem_sh;
				quo <= {quo[NUMW-2:0], 1'b0};
			end
		end else if (div_busy) begin
			div_busy <= 1'b0;
			unbal    <= (den == '0) ? 8'h00 : quo[7:0];
		end
	end

	always_comb begin
		unique case (disp_sel)
			rcsm_pkg::DISP_L1:    disp_src = CUR_L1;
			rcsm_pkg::DISP_L2:    disp_src = CUR_L2;
			rcsm_pkg::DISP_L3:    disp_src = CUR_L3;
			rcsm_pkg::DISP_RES:   disp_src = RESIDUAL_CURRENT;
			rcsm_pkg::DISP_UNBAL: disp_src = CUR_W'(unbal);
			default:              disp_src = '0;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			DISP_VALUE <= '0;
			DISP_LED   <= '0;
		end else begin
			DISP_VALUE <= (disp_src > CUR_W'(rcsm_pkg::DISP_MAX)) ? rcsm_pkg::DISP_MAX : 12'(disp_src);
			// unbalance lives in the residual submenu, so it lights that indicator
			DISP_LED   <= (disp_sel == rcsm_pkg::DISP_UNBAL) ? 4'h8 : 4'(1 << disp_sel);
		end
	end

	// register read decode
	always_comb begin
		logic [rcsm_pkg::ADDR_W-1:0] off;
		off     = '0;
		rd_data = '0;
		rd_ok   = 1'b1;
		if (ARADDR == rcsm_pkg::ADDR_BANK_CMD) begin
			rd_data[0] = bank_cmd;
		end else if (ARADDR == rcsm_pkg::ADDR_LATCH_EN) begin
			rd_data[rcsm_pkg::NUM_OUT-1:0] = latch_en;
		end else if (ARADDR == rcsm_pkg::ADDR_DISP_SEL) begin
			rd_data[2:0] = disp_sel;
		end else if (ARADDR == rcsm_pkg::ADDR_STATUS) begin
			rd_data[rcsm_pkg::ST_BANK] = BANK_SEL;
			rd_data[rcsm_pkg::ST_BLOCK +: rcsm_pkg::NUM_STG] = STAGE_BLOCK;
			rd_data[rcsm_pkg::ST_SS +: rcsm_pkg::NUM_OUT] = START_OUTPUTS;
			rd_data[rcsm_pkg::ST_TS +: rcsm_pkg::NUM_OUT] = TRIP_OUTPUTS;
			rd_data[rcsm_pkg::ST_IND +: rcsm_pkg::NUM_OUT] = TRIP_IND;
		end else if (ARADDR[1:0] == 2'h0 && ARADDR >= rcsm_pkg::ADDR_SWGRP
				&& ARADDR < rcsm_pkg::ADDR_SWGRP + 8'(4 * rcsm_pkg::NUM_GRP)) begin
			off = ARADDR - rcsm_pkg::ADDR_SWGRP;
			rd_data[rcsm_pkg::SW_W-1:0] = swgrp[off[5:2]];
		end else if (ARADDR[1:0] == 2'h0 && ARADDR >= rcsm_pkg::ADDR_CKSUM
				&& ARADDR < rcsm_pkg::ADDR_CKSUM + 8'(4 * rcsm_pkg::NUM_GRP)) begin
			off = ARADDR - rcsm_pkg::ADDR_CKSUM;
			rd_data[rcsm_pkg::SW_W-1:0] = cksum(swgrp[off[5:2]]);
		end else if (ARADDR[1:0] == 2'h0 && ARADDR >= rcsm_pkg::ADDR_RECORD
				&& ARADDR < rcsm_pkg::ADDR_RECORD + 8'(4 * rcsm_pkg::NUM_CUR)) begin
			off = ARADDR - rcsm_pkg::ADDR_RECORD;
			rd_data[CUR_W-1:0] = rec[off[3:2]];
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		wr_ok = (aw_addr == rcsm_pkg::ADDR_BANK_CMD) || (aw_addr == rcsm_pkg::ADDR_LATCH_EN)
			|| (aw_addr == rcsm_pkg::ADDR_DISP_SEL)
			|| (aw_addr[1:0] == 2'h0 && aw_addr >= rcsm_pkg::ADDR_SWGRP
			&& aw_addr < rcsm_pkg::ADDR_SWGRP + 8'(4 * rcsm_pkg::NUM_GRP));
	end

	// write channel: address and data accepted in either order, one write at a time
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			AWREADY <= 1'b0;
			WREADY  <= 1'b0;
			BVALID  <= 1'b0;
			BRESP   <= rcsm_pkg::RESP_OKAY;
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_addr <= '0;
			w_byte  <= '0;
			w_lane  <= 1'b0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got  <= 1'b1;
				aw_addr <= AWADDR;
				AWREADY <= 1'b0;
			end else if (!aw_got && !BVALID) begin
				AWREADY <= 1'b1;
			end
			if (WVALID && WREADY) begin
				w_got  <= 1'b1;
				w_byte <= WDATA[rcsm_pkg::SW_W-1:0];
				w_lane <= WSTRB[0];
				WREADY <= 1'b0;
			end else if (!w_got && !BVALID) begin
				WREADY <= 1'b1;
			end
			if (aw_got && w_got && !BVALID) begin
				aw_got <= 1'b0;
				w_got  <= 1'b0;
				BVALID <= 1'b1;
				BRESP  <= wr_ok ? rcsm_pkg::RESP_OKAY : rcsm_pkg::RESP_SLVERR;
			end else if (BVALID && BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			bank_cmd <= 1'b0;
			latch_en <= rcsm_pkg::RST_LATCH;
			disp_sel <= rcsm_pkg::DISP_L1;
			for (int g = 0; g < rcsm_pkg::NUM_GRP; g++) begin
				swgrp[g] <= rcsm_pkg::RST_SW;
			end
		end else if (aw_got && w_got && !BVALID && w_lane) begin
			if (aw_addr == rcsm_pkg::ADDR_BANK_CMD) begin
				bank_cmd <= w_byte[0];
			end else if (aw_addr == rcsm_pkg::ADDR_LATCH_EN) begin
				latch_en <= w_byte[rcsm_pkg::NUM_OUT-1:0];
			end else if (aw_addr == rcsm_pkg::ADDR_DISP_SEL) begin
				if (w_byte[2:0] <= rcsm_pkg::DISP_UNBAL) begin
					disp_sel <= rcsm_pkg::rcsm_disp_type'(w_byte[2:0]);
				end
			end else if (wr_ok) begin
				swgrp[4'((aw_addr - rcsm_pkg::ADDR_SWGRP) >> 2)] <= w_byte;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b0;
			RDATA   <= '0;
			RRESP   <= rcsm_pkg::RESP_OKAY;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= rd_data;
			RRESP   <= rd_ok ? rcsm_pkg::RESP_OKAY : rcsm_pkg::RESP_SLVERR;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
		end else if (!RVALID) begin
			ARREADY <= 1'b1;
		end
	end
endmodule

/* rcsm_asserts.sv */
`timescale 1ns/100ps
module rcsm_asserts (
	input wire logic                         CLOCK,           // clock
	input wire logic                         RST_B,           // async reset, active low
	input wire logic                         EXT_BLOCK_IN_A,  // control input 1
	input wire logic                         EXT_BLOCK_IN_B,  // control input 2
	input wire logic                         REMOTE_CLEAR_IN, // control input 3
	input wire logic [rcsm_pkg::NUM_STG-1:0] STAGE_BLOCK,     // stage blocked
	input wire logic [rcsm_pkg::NUM_STG-1:0] STAGE_START,     // stage starts
	input wire logic [rcsm_pkg::NUM_STG-1:0] STAGE_OPER,      // stage operates
	input wire logic                         AWVALID,         // write address valid
	input wire logic                         AWREADY,         // write address ready
	input wire logic                         WVALID,          // write data valid
	input wire logic                         WREADY,          // write data ready
	input wire logic [1:0]                   BRESP,           // write response
	input wire logic                         BVALID,          // write response valid
	input wire logic                         BREADY,          // write response ready
	input wire logic                         ARVALID,         // read address valid
	input wire logic                         ARREADY,         // read address ready
	input wire logic [31:0]                  RDATA,           // read data
	input wire logic                         RVALID,          // read data valid
	input wire logic                         RREADY,          // read data ready
	input wire logic [rcsm_pkg::NUM_OUT-1:0] START_OUTPUTS,   // start outputs
	input wire logic [rcsm_pkg::NUM_OUT-1:0] TRIP_IND,        // operation indicators
	input wire logic [3:0]                   DISP_LED         // quantity indicators
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	a_block_idle: assert property (!EXT_BLOCK_IN_A && !EXT_BLOCK_IN_B && !REMOTE_CLEAR_IN |=> STAGE_BLOCK == '0)
		else $error("stage blocked with no control input high");
	a_start_idle: assert property (STAGE_START == '0 && STAGE_OPER == '0 |=> START_OUTPUTS == '0)
		else $error("start output with no stage signal");
	// indicators may only fall after some control input was high
	a_ind_sticky: assert property (!EXT_BLOCK_IN_A && !EXT_BLOCK_IN_B && !REMOTE_CLEAR_IN
		|=> (TRIP_IND & $past(TRIP_IND)) == $past(TRIP_IND))
		else $error("indicator cleared without a clear input");
	a_led_onehot: assert property ($past(RST_B) |-> $onehot(DISP_LED))
		else $error("display indicator not one-hot");
	a_aw_refused: assert property (AWVALID && AWREADY |=> !AWREADY)
		else $error("write address accepted twice");
	a_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> ##[0:1] BVALID)
		else $error("write response late");
	a_read_answer: assert property (ARVALID && ARREADY |=> ##[0:1] RVALID)
		else $error("read data late");
	a_b_stands: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	a_r_stands: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
		else $error("read data dropped early");
endmodule

bind rcsm_top rcsm_asserts u_rcsm_asserts (.CLOCK, .RST_B, .EXT_BLOCK_IN_A, .EXT_BLOCK_IN_B, .REMOTE_CLEAR_IN,
	.STAGE_START, .STAGE_OPER, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID,
	.ARREADY, .RDATA, .RVALID, .RREADY, .START_OUTPUTS, .TRIP_IND, .DISP_LED, .STAGE_BLOCK);

/* rcsm_master.sv */
`timescale 1ns/100ps
module rcsm_master (
	input  wire logic        clk,     // bus clock
	output logic [7:0]       awaddr,  // write address
	output logic             awvalid, // write address valid
	input  wire logic        awready, // write address ready
	output logic [31:0]      wdata,   // write data
	output logic             wvalid,  // write data valid
	input  wire logic        wready,  // write data ready
	input  wire logic        bvalid,  // write response valid
	output logic             bready,  // write response ready
	output logic [7:0]       araddr,  // read address
	output logic             arvalid, // read address valid
	input  wire logic        arready, // read address ready
	input  wire logic        rvalid,  // read data valid
	output logic             rready   // read data ready
);
	initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;

	// one settings set serves both banks, so the bank switch is always equal in both
	// the bank command is an ordinary register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ap;
		logic wp;
		ap = 1'b1;
		wp = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (ap || wp) begin
			@(posedge clk);
			if (ap && awready) begin
				ap = 1'b0;
				awvalid <= 1'b0;
			end
			if (wp && wready) begin
				wp = 1'b0;
				wvalid <= 1'b0;
			end
		end
		// ready is raised in the cycle the response turns valid, so the response never has to stand
		@(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
endmodule

/* tb_relay_control_signal_matrix.sv */
`timescale 1ns/100ps
module tb_relay_control_signal_matrix;
	`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
		$display("[FAIL] %s exp %h got %h", nm, e, g); end end
	logic        clk = 1'b0, rst_b = 1'b0, blk_a = 1'b0, blk_b = 1'b0, clr_in = 1'b0, look = 1'b0;
	logic [5:0]  st_start = 6'h00, st_oper = 6'h00;
	logic [11:0] cur [4] = '{12'h064, 12'h032, 12'h050, 12'h4B0};
	logic [7:0]  awaddr, araddr, v;
	logic [31:0] wdata, rdata;
	logic [1:0]  rresp, bresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [11:0] disp_value;
	logic [3:0]  disp_led;
	logic [33:0] e;
	logic [33:0] exp_q [$];
	int          n_mismatch = 0, tests_run = 0, seed = 9;

	always #4 clk = ~clk;

	rcsm_top u_rcsm_top (.CLOCK(clk), .RST_B(rst_b), .EXT_BLOCK_IN_A(blk_a), .EXT_BLOCK_IN_B(blk_b),
		.REMOTE_CLEAR_IN(clr_in), .STAGE_START(st_start), .STAGE_OPER(st_oper), .CUR_L1(cur[0]), .CUR_L2(cur[1]),
		.CUR_L3(cur[2]), .RESIDUAL_CURRENT(cur[3]), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .STAGE_BLOCK(), .BANK_SEL(),
		.START_OUTPUTS(), .TRIP_OUTPUTS(), .TRIP_IND(), .DISP_VALUE(disp_value), .DISP_LED(disp_led));

	rcsm_master u_rcsm_master (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rvalid(rvalid), .rready(rready));

	// read data and display snapshots arrive in the order they were noted
	always @(posedge clk) begin
		if ((rvalid && rready) || (bvalid && bready) || look) begin
			e = exp_q.pop_front();
			if (look)
				`CHK("display", e, {18'h0_0000, disp_led, disp_value})
			else if (bvalid)
				`CHK("bresp", e, {bresp, 32'h0000_0000})
			else
				`CHK("read", e, {rresp, rdata})
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs = rcsm_pkg::RESP_OKAY);
		exp_q.push_back({rs, 32'h0000_0000});
		u_rcsm_master.wr(a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] rs = rcsm_pkg::RESP_OKAY);
		exp_q.push_back({rs, x});
		u_rcsm_master.rd(a);
	endtask

	task automatic disp(input logic [2:0] s, input logic [15:0] x);
		wr(rcsm_pkg::ADDR_DISP_SEL, {5'h00, s});
		tick(4);
		exp_q.push_back({18'h0_0000, x});
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		tick(20000);
		n_mismatch++;
		wrap_up;
	end

	initial begin
		tick(2);
		rst_b <= 1'b1;
		tick(1);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0000);
		rd(8'hF0, 32'h0000_0000, rcsm_pkg::RESP_SLVERR);
		wr(rcsm_pkg::ADDR_STATUS, 8'h01, rcsm_pkg::RESP_SLVERR);
		for (int g = 0; g < rcsm_pkg::NUM_GRP; g++) begin
			v = 8'($random(seed));
			wr(rcsm_pkg::ADDR_SWGRP + 8'(4 * g), v);
			rd(rcsm_pkg::ADDR_SWGRP + 8'(4 * g), {24'h00_0000, v});
			rd(rcsm_pkg::ADDR_CKSUM + 8'(4 * g), {24'h00_0000, v});
			wr(rcsm_pkg::ADDR_SWGRP + 8'(4 * g), 8'h00);
		end
		wr(rcsm_pkg::ADDR_SWGRP, 8'h21);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h04, 8'h04);
		blk_a <= 1'b1;
		blk_b <= 1'b1;
		tick(2);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_004A);
		blk_a <= 1'b0;
		blk_b <= 1'b0;
		wr(rcsm_pkg::ADDR_BANK_CMD, 8'h01);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0001);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h08, 8'h10);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0000);
		clr_in <= 1'b1;
		tick(2);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0001);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h08, 8'h00);
		wr(rcsm_pkg::ADDR_BANK_CMD, 8'h00);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0000);
		clr_in <= 1'b0;
		// routing group 5 carries the operate signal of stage 0
		wr(rcsm_pkg::ADDR_SWGRP + 8'h10, 8'h11);
		wr(rcsm_pkg::ADDR_LATCH_EN, 8'h01);
		st_start <= 6'h01;
		st_oper <= 6'h01;
		tick(2);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_8880);
		st_start <= 6'h00;
		st_oper <= 6'h00;
		tick(2);
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_8800);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h04, 8'h20);
		blk_b <= 1'b1;
		tick(2);
		blk_b <= 1'b0;
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0800);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h08, 8'h40);
		clr_in <= 1'b1;
		tick(2);
		clr_in <= 1'b0;
		rd(rcsm_pkg::ADDR_STATUS, 32'h0000_0000);
		rd(rcsm_pkg::ADDR_RECORD, 32'h0000_0064);
		wr(rcsm_pkg::ADDR_SWGRP + 8'h08, 8'h80);
		clr_in <= 1'b1;
		tick(2);
		clr_in <= 1'b0;
		rd(rcsm_pkg::ADDR_RECORD, 32'h0000_0000);
		tick(1300);
		disp(3'h0, 16'h1064);
		disp(3'h1, 16'h2032);
		disp(3'h2, 16'h4050);
		disp(3'h3, 16'h83E7);
		disp(3'h4, 16'h8032);
		wrap_up;
	end
endmodule
